// ===== inc/wg_pkg.sv
// constants, state codes and carrier types of the pad waveform generator
// assumes a 32-bit apb slave with one register per aligned word
package wg_pkg;

  // ----------------------------------------------------------------
  // register indexes; byte address is four times the index
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam logic [13:0] IDX_T47 = 14'h10AC;
  localparam logic [13:0] IDX_T46 = 14'h10AD;
  localparam logic [13:0] IDX_N7 = 14'h10AE;
  localparam logic [13:0] IDX_N6 = 14'h10AF;
  localparam logic [13:0] IDX_CFG = 14'h10B0;
  localparam logic [13:0] IDX_CHAIN = 14'h10B1;
  localparam logic [13:0] IDX_CLKDIV = 14'h10B2;
  localparam logic [13:0] IDX_DIVSEL = 14'h10B3;
  localparam logic [13:0] IDX_WRESET = 14'h10B5;
  localparam logic [13:0] IDX_SUSP = 14'h10B6;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int NUM_PADS = 8;
  localparam int NUM_PAIRS = 4;
  localparam int CFG_EN_LSB = 0;
  localparam int CFG_MODE_LSB = 4;
  localparam int DIV1_LSB = 0;
  localparam int DIV2_LSB = 4;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [6:0] RST_CHAIN = 7'h00;
  localparam logic [15:0] RST_DIVCNT = 16'h0000;
  localparam logic [15:0] DEF_SUB_LEN = 16'h0001;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAIT = 3'b001,
    ST_HIGH = 3'b010,
    ST_LOW = 3'b011,
    ST_DONE = 3'b100
  } wave_state_t;

  typedef struct packed {
    logic [15:0] sub_len;
    logic [15:0] cnt_load;
  } wave_cfg_t;

endpackage

// ===== core/wave_channel.sv
// one pad's waveform counter: high and low subperiods, period count
// assumes run, hold, chain and tick come from the register block
`timescale 1ns/10ps
module wave_channel (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire wg_pkg::wave_cfg_t cfg_i,
  input wire logic run_i,
  input wire logic hold_i,
  input wire logic chain_i,
  input wire logic go_i,
  input wire logic tick_i,
  input wire logic reload_i,
  output logic wave_o,
  output logic wait_o,
  output logic fin_o,
  output logic [15:0] rem_o
);
  wg_pkg::wave_state_t state_r, state_nxt;
  logic [15:0] sub_r, sub_nxt;
  logic [15:0] rem_r, rem_nxt;
  logic wave_r, wave_nxt;
  logic expire;

  assign expire = tick_i && !hold_i && (sub_r == cfg_i.sub_len);
  // finish is combinational so a chained pad starts on the same edge
  assign fin_o = (state_r == wg_pkg::ST_LOW) && expire && (rem_r == 16'h0001);
  assign wave_o = wave_r;
  assign wait_o = (state_r == wg_pkg::ST_WAIT);
  assign rem_o = rem_r;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    sub_nxt = sub_r;
    rem_nxt = rem_r;
    wave_nxt = wave_r;
    if (!run_i) begin
      state_nxt = wg_pkg::ST_IDLE;
      sub_nxt = 16'h0000;
      rem_nxt = 16'h0000;
      wave_nxt = 1'b0;
    end else begin
      case (state_r)
        wg_pkg::ST_IDLE: begin
          if (!hold_i) begin
            rem_nxt = cfg_i.cnt_load;
            sub_nxt = 16'h0000;
            state_nxt = chain_i ? wg_pkg::ST_WAIT : wg_pkg::ST_HIGH;
            wave_nxt = !chain_i;
          end
        end
        wg_pkg::ST_WAIT: begin
          if (go_i) begin
            state_nxt = wg_pkg::ST_HIGH;
            wave_nxt = 1'b1;
          end
        end
        wg_pkg::ST_HIGH, wg_pkg::ST_LOW: begin
          if (tick_i && !hold_i) begin
            sub_nxt = sub_r + 16'h0001;
            if (expire) begin
              sub_nxt = 16'h0000;
              if (state_r == wg_pkg::ST_HIGH) begin
                state_nxt = wg_pkg::ST_LOW;
                wave_nxt = 1'b0;
              end else if (rem_r == 16'h0001) begin
                rem_nxt = 16'h0000;
                state_nxt = wg_pkg::ST_DONE;
              end else begin
                if (rem_r != 16'h0000) begin
                  rem_nxt = rem_r - 16'h0001;
                end
                state_nxt = wg_pkg::ST_HIGH;
                wave_nxt = 1'b1;
              end
            end
          end
        end
        wg_pkg::ST_DONE: begin
          state_nxt = wg_pkg::ST_DONE;
        end
        default: begin
          state_nxt = wg_pkg::ST_IDLE;
        end
      endcase
      if (reload_i) begin
        rem_nxt = cfg_i.cnt_load;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_r <= wg_pkg::ST_IDLE;
      sub_r <= 16'h0000;
      rem_r <= 16'h0000;
      wave_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      sub_r <= sub_nxt;
      rem_r <= rem_nxt;
      wave_r <= wave_nxt;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_reset_clears: assert property (
    @(posedge clk_i) disable iff (srst_i)
    !run_i |=> (state_r == wg_pkg::ST_IDLE) && !wave_r && (rem_r == 16'h0000))
    else $error("halted pad did not clear");

  chk_suspend_hold: assert property (
    @(posedge clk_i) disable iff (srst_i)
    run_i && hold_i && ((state_r == wg_pkg::ST_HIGH) || (state_r == wg_pkg::ST_LOW))
    |=> $stable(sub_r) && $stable(wave_r))
    else $error("suspended pad kept counting");

  chk_infinite_run: assert property (
    @(posedge clk_i) disable iff (srst_i)
    run_i && !reload_i && (state_r == wg_pkg::ST_LOW) && expire && (rem_r == 16'h0000)
    |=> (state_r == wg_pkg::ST_HIGH) && wave_r)
    else $error("infinite waveform stopped");

  chk_finish_done: assert property (
    @(posedge clk_i) disable iff (srst_i)
    fin_o && run_i |=> (state_r == wg_pkg::ST_DONE) [*2])
    else $error("finished pad did not stop");
endmodule

// ===== core/gpio_waveform_generator.sv
// pad waveform generator: apb registers, dividers, eight pad channels
// assumes apb master on clk_i; pad muxing sits outside this block
//
// Overview of operation
// - pad-7 fifth subperiod: pad 7 length, or upper byte of pad 6's
// - pad-6 fifth subperiod: pad 6 length, or its lower byte
// - pad-7 count write: pad 7 periods, or upper byte of pad 6 count
// - pad-6 count write: pad 6 periods, or lower byte of its count
// - a zero period count runs the waveform forever
// - count reads return periods still to generate
// - low four config bits enable generation on each pad pair
// - clear mode bit: both pads of the pair run with 8-bit counters
// - set mode bit: odd pad released, even pad uses 16-bit counter
// - chain bits make one waveform start as another ends
// - even chain bit: start after next pad, or pad after next in 16-bit
// - odd chain bit: start after the next pad, 8-bit mode only
// - chain bit 6: pad 6 starts after pad 7, 8-bit mode only
// - two dividers divide clock by two to the power d+1
// - per-pad select bit picks divider 1 or divider 2
// - per-pad reset bit halts and clears until software clears it
// - per-pad suspend bit pauses generation, but a chained pad still starts; clearing resumes it where it paused
//
// The APB register port was decided locally.
`timescale 1ns/10ps
module gpio_waveform_generator #(
  parameter logic [15:0] DEF_SUB_LEN = wg_pkg::DEF_SUB_LEN
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [wg_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic [7:0] wave_o,
  output logic [7:0] drive_o
);
  localparam int NP = wg_pkg::NUM_PADS;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [15:0] a, input logic [13:0] idx);
    return (a[1:0] == 2'b00) && (a[15:2] == idx);
  endfunction

  function automatic logic div_tick(input logic [15:0] c, input logic [3:0] d);
    logic [15:0] m;
    m = 16'hFFFF >> (4'hF - d);
    return (c & m) == m;
  endfunction

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [7:0] t47_r, t47_nxt, t46_r, t46_nxt;
  logic [7:0] n7_r, n7_nxt, n6_r, n6_nxt;
  logic [7:0] cfg_r, cfg_nxt;
  logic [6:0] chain_r, chain_nxt;
  logic [7:0] clkdiv_r, clkdiv_nxt, divsel_r, divsel_nxt;
  logic [7:0] wreset_r, wreset_nxt, susp_r, susp_nxt;
  logic wr_acc, rd_setup;
  logic wr_n7, wr_n6;

  assign wr_acc = psel_i && penable_i && pwrite_i && pready_o;
  assign rd_setup = psel_i && !penable_i && !pwrite_i;
  assign wr_n7 = wr_acc && hit(paddr_i, wg_pkg::IDX_N7);
  assign wr_n6 = wr_acc && hit(paddr_i, wg_pkg::IDX_N6);

  always_comb begin
    t47_nxt = t47_r;
    t46_nxt = t46_r;
    n7_nxt = n7_r;
    n6_nxt = n6_r;
    cfg_nxt = cfg_r;
    chain_nxt = chain_r;
    clkdiv_nxt = clkdiv_r;
    divsel_nxt = divsel_r;
    wreset_nxt = wreset_r;
    susp_nxt = susp_r;
    if (wr_acc && (paddr_i[1:0] == 2'b00)) begin
      case (paddr_i[15:2])
        wg_pkg::IDX_T47: t47_nxt = pwdata_i[7:0];
        wg_pkg::IDX_T46: t46_nxt = pwdata_i[7:0];
        wg_pkg::IDX_N7: n7_nxt = pwdata_i[7:0];
        wg_pkg::IDX_N6: n6_nxt = pwdata_i[7:0];
        wg_pkg::IDX_CFG: cfg_nxt = pwdata_i[7:0];
        wg_pkg::IDX_CHAIN: chain_nxt = pwdata_i[6:0];
        wg_pkg::IDX_CLKDIV: clkdiv_nxt = pwdata_i[7:0];
        wg_pkg::IDX_DIVSEL: divsel_nxt = pwdata_i[7:0];
        wg_pkg::IDX_WRESET: wreset_nxt = pwdata_i[7:0];
        wg_pkg::IDX_SUSP: susp_nxt = pwdata_i[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      t47_r <= wg_pkg::RST_BYTE;
      t46_r <= wg_pkg::RST_BYTE;
      n7_r <= wg_pkg::RST_BYTE;
      n6_r <= wg_pkg::RST_BYTE;
      cfg_r <= wg_pkg::RST_BYTE;
      chain_r <= wg_pkg::RST_CHAIN;
      clkdiv_r <= wg_pkg::RST_BYTE;
      divsel_r <= wg_pkg::RST_BYTE;
      wreset_r <= wg_pkg::RST_BYTE;
      susp_r <= wg_pkg::RST_BYTE;
    end else begin
      t47_r <= t47_nxt;
      t46_r <= t46_nxt;
      n7_r <= n7_nxt;
      n6_r <= n6_nxt;
      cfg_r <= cfg_nxt;
      chain_r <= chain_nxt;
      clkdiv_r <= clkdiv_nxt;
      divsel_r <= divsel_nxt;
      wreset_r <= wreset_nxt;
      susp_r <= susp_nxt;
    end
  end

  // ----------------------------------------------------------------
  // clock dividers
  // ----------------------------------------------------------------
  logic [15:0] divcnt_r, divcnt_nxt;
  logic tick1, tick2;

  // divide by two to the d+1
  assign tick1 = div_tick(divcnt_r, clkdiv_r[wg_pkg::DIV1_LSB +: 4]);
  assign tick2 = div_tick(divcnt_r, clkdiv_r[wg_pkg::DIV2_LSB +: 4]);

  always_comb begin
    divcnt_nxt = divcnt_r + 16'h0001;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      divcnt_r <= wg_pkg::RST_DIVCNT;
    end else begin
      divcnt_r <= divcnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // per-pad steering
  // ----------------------------------------------------------------
  logic mode16_3;
  logic [NP-1:0] run_w, chain_w, go_w, tick_w, reload_w;
  logic [NP-1:0] wave_w, wait_w, fin_w;
  logic [NP+1:0] fin_x;
  logic [15:0] rem_w [NP];
  wg_pkg::wave_cfg_t wcfg [NP];

  assign mode16_3 = cfg_r[wg_pkg::CFG_MODE_LSB + 3];
  assign fin_x = {2'b00, fin_w};

  always_comb begin
    for (int p = 0; p < NP; p++) begin
      // pair enable, odd pad released in 16-bit mode
      run_w[p] = cfg_r[wg_pkg::CFG_EN_LSB + p / 2] && !wreset_r[p]
        && !((p % 2 == 1) && cfg_r[wg_pkg::CFG_MODE_LSB + p / 2]);
      tick_w[p] = divsel_r[p] ? tick2 : tick1;
      chain_w[p] = 1'b0;
      go_w[p] = 1'b0;
      if (p < NP - 1) begin
        if (cfg_r[wg_pkg::CFG_MODE_LSB + p / 2]) begin
          // even pad follows pad after next; odd bits ignored
          chain_w[p] = chain_r[p] && (p % 2 == 0) && (p < NP - 2);
          go_w[p] = fin_x[p + 2];
        end else begin
          // follow the next pad in 8-bit mode
          chain_w[p] = chain_r[p];
          go_w[p] = fin_x[p + 1];
        end
      end
      wcfg[p].sub_len = DEF_SUB_LEN;
      wcfg[p].cnt_load = 16'h0000;
      reload_w[p] = 1'b0;
    end
    // fifth subperiod bytes, 8-bit or 16-bit
    wcfg[6].sub_len = mode16_3 ? {t47_r, t46_r} : {8'h00, t46_r};
    wcfg[7].sub_len = {8'h00, t47_r};
    wcfg[6].cnt_load = mode16_3 ? {n7_r, n6_r} : {8'h00, n6_r};
    wcfg[7].cnt_load = {8'h00, n7_r};
    reload_w[6] = wr_n6 || (mode16_3 && wr_n7);
    reload_w[7] = wr_n7 && !mode16_3;
  end

  generate
    for (genvar g = 0; g < NP; g++) begin : g_pad
      wave_channel u_chan (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .cfg_i(wcfg[g]),
        .run_i(run_w[g]),
        .hold_i(susp_r[g]),
        .chain_i(chain_w[g]),
        .go_i(go_w[g]),
        .tick_i(tick_w[g]),
        .reload_i(reload_w[g]),
        .wave_o(wave_w[g]),
        .wait_o(wait_w[g]),
        .fin_o(fin_w[g]),
        .rem_o(rem_w[g])
      );
    end
  endgenerate

  assign wave_o = wave_w;

  // ----------------------------------------------------------------
  // pad ownership
  // ----------------------------------------------------------------
  logic [7:0] drive_r, drive_nxt;

  always_comb begin
    // disabled pads stay with ordinary gpio logic
    drive_nxt = run_w;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      drive_r <= 8'h00;
    end else begin
      drive_r <= drive_nxt;
    end
  end

  assign drive_o = drive_r;

  // ----------------------------------------------------------------
  // apb answer
  // ----------------------------------------------------------------
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic [7:0] shadow_r, shadow_nxt;
  logic shv_r, shv_nxt;
  logic mapped;

  always_comb begin
    mapped = 1'b0;
    prdata_nxt = 32'h0000_0000;
    shadow_nxt = shadow_r;
    shv_nxt = shv_r;
    if (paddr_i[1:0] == 2'b00) begin
      mapped = 1'b1;
      case (paddr_i[15:2])
        wg_pkg::IDX_T47: prdata_nxt[7:0] = t47_r;
        wg_pkg::IDX_T46: prdata_nxt[7:0] = t46_r;
        // remaining count, upper byte latches lower for coherence
        wg_pkg::IDX_N7: prdata_nxt[7:0] = mode16_3 ? rem_w[6][15:8] : rem_w[7][7:0];
        wg_pkg::IDX_N6: prdata_nxt[7:0] = (mode16_3 && shv_r) ? shadow_r : rem_w[6][7:0];
        wg_pkg::IDX_CFG: prdata_nxt[7:0] = cfg_r;
        wg_pkg::IDX_CHAIN: prdata_nxt[6:0] = chain_r;
        wg_pkg::IDX_CLKDIV: prdata_nxt[7:0] = clkdiv_r;
        wg_pkg::IDX_DIVSEL: prdata_nxt[7:0] = divsel_r;
        wg_pkg::IDX_WRESET: prdata_nxt[7:0] = wreset_r;
        wg_pkg::IDX_SUSP: prdata_nxt[7:0] = susp_r;
        default: mapped = 1'b0;
      endcase
    end
    if (!rd_setup) begin
      prdata_nxt = 32'h0000_0000;
    end else if (mode16_3 && hit(paddr_i, wg_pkg::IDX_N7)) begin
      shadow_nxt = rem_w[6][7:0];
      shv_nxt = 1'b1;
    end else if (hit(paddr_i, wg_pkg::IDX_N6)) begin
      shv_nxt = 1'b0;
    end
    // one wait-free access cycle: answer is ready in the first access phase
    pready_nxt = psel_i && !penable_i;
    pslverr_nxt = psel_i && !penable_i && !mapped;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      shadow_r <= 8'h00;
      shv_r <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      shadow_r <= shadow_nxt;
      shv_r <= shv_nxt;
    end
  end

  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_apb_answer: assert property (
    @(posedge clk_i) disable iff (srst_i)
    psel_i && !penable_i |=> pready_o)
    else $error("apb setup not answered");

  chk_pair_enable: assert property (
    @(posedge clk_i) disable iff (srst_i)
    !cfg_r[0] |=> !drive_o[0] && !wave_o[0])
    else $error("disabled pair still driven");

  chk_mode16_off: assert property (
    @(posedge clk_i) disable iff (srst_i)
    cfg_r[7] |=> !drive_o[7] && !wave_o[7])
    else $error("odd pad driven in 16-bit mode");

  chk_chain_start: assert property (
    @(posedge clk_i) disable iff (srst_i)
    fin_w[7] && chain_r[6] && !mode16_3 && wait_w[6] && run_w[6] |=> wave_o[6])
    else $error("pad 6 did not follow pad 7");

  chk_div_tick: assert property (
    @(posedge clk_i) disable iff (srst_i)
    tick1 && $stable(clkdiv_r) |=> !tick1)
    else $error("divider ticked twice in a row");

  chk_count_read: assert property (
    @(posedge clk_i) disable iff (srst_i)
    rd_setup && hit(paddr_i, wg_pkg::IDX_N7) && !mode16_3
    |=> prdata_o[7:0] == $past(rem_w[7][7:0]))
    else $error("count read mismatch");
endmodule

// ===== dv/pad_monitor.sv
// external load on the eight pads: counts driven rising edges, times each pad
// assumes wave and drive come from the generator on the same clock
`timescale 1ns/10ps
module pad_monitor (
  input wire logic clk_i,
  input wire logic clr_i,
  input wire logic [7:0] wave_i,
  input wire logic [7:0] drive_i,
  output logic [15:0] rise_cnt_o [8],
  output logic [15:0] per_o [8]
);
  logic [7:0] prev_r;
  logic [15:0] cyc_r;
  logic [15:0] last_r [8];

  // a released pad is not counted: only owned edges count as pulses
  // per_o holds the last rise-to-rise interval; the first one is not exact
  always_ff @(posedge clk_i) begin
    prev_r <= wave_i;
    cyc_r <= clr_i ? 16'h0000 : cyc_r + 16'h0001;
    for (int k = 0; k < 8; k++) begin
      if (clr_i) begin
        rise_cnt_o[k] <= 16'h0000;
        per_o[k] <= 16'h0000;
        last_r[k] <= 16'h0000;
      end else if (wave_i[k] && !prev_r[k] && drive_i[k]) begin
        rise_cnt_o[k] <= rise_cnt_o[k] + 16'h0001;
        per_o[k] <= cyc_r - last_r[k];
        last_r[k] <= cyc_r;
      end
    end
  end
endmodule

// ===== dv/tb_top.sv
// self-checking bench: apb master, pad monitor, directed and random cases
// assumes the generator answers apb with no wait states, one clock domain
`timescale 1ns/10ps
module tb_top;
  logic clk_i = 1'b0, srst_i = 1'b1, clr = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, seed = 32'h4F2D1DD0;
  logic pready, pslverr;
  logic [7:0] wave, drive, rd, t46, d2;
  logic [15:0] cnt [8], per [8], c;
  logic err;
  int n_mismatch = 0, tests_run = 0, cyc = 0;

  gpio_waveform_generator i_dut (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .wave_o(wave), .drive_o(drive));
  pad_monitor i_pads (.clk_i(clk_i), .clr_i(clr), .wave_i(wave), .drive_i(drive),
    .rise_cnt_o(cnt), .per_o(per));

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [15:0] exp_per(input logic [15:0] sub, input logic [7:0] d);
    return 16'(2 * (sub + 1) * (2 << d));
  endfunction

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // upper write bits are random: the register must ignore them
  task automatic apb(input logic wr, input logic [13:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= (xs() & 32'hFFFF_FF00) | {24'h000000, wd};
    @(posedge clk_i);
    penable <= 1'b1;
    // pready and data are read at the rising edge, before the flops update
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_mismatch++;
    end
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic wait_cnt(input int pad, input logic [15:0] n);
    int k;
    k = 0;
    while (cnt[pad] !== n && k < 5000) begin
      @(negedge clk_i);
      k++;
    end
  endtask

  task automatic restart();
    apb(1'b1, wg_pkg::IDX_WRESET, 8'hFF);
    apb(1'b1, wg_pkg::IDX_CFG, 8'h00);
    apb(1'b1, wg_pkg::IDX_CHAIN, 8'h00);
    apb(1'b1, wg_pkg::IDX_SUSP, 8'h00);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    apb(1'b1, wg_pkg::IDX_WRESET, 8'h00);
  endtask

  // a hang is cut short here and reported like any mismatch
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    clr <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 14'(wg_pkg::IDX_T47 + i), 8'h00);
      chk("reset value", 32'(wg_pkg::RST_BYTE), {24'h0, rd});
      chk("mapped error", 32'h0, {31'h0, err});
    end
    apb(1'b0, 14'h10B4, 8'h00);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, {24'h0, rd});
    // register storage with random contents, generation still disabled
    t46 = 8'(xs());
    apb(1'b1, wg_pkg::IDX_T47, t46);
    apb(1'b0, wg_pkg::IDX_T47, 8'h00);
    chk("pad7 subperiod", {24'h0, t46}, {24'h0, rd});
    apb(1'b1, wg_pkg::IDX_CHAIN, t46);
    apb(1'b0, wg_pkg::IDX_CHAIN, 8'h00);
    chk("chain select", {25'h0, t46[6:0]}, {24'h0, rd});
    chk("idle drive", 32'h0, {24'h0, drive});
    // 8-bit pair 3, random subperiod, pad 6 on divider 2
    restart();
    t46 = 8'(xs() & 32'h3);
    d2 = 8'(xs() & 32'h1);
    apb(1'b1, wg_pkg::IDX_T46, t46);
    apb(1'b1, wg_pkg::IDX_T47, 8'h00);
    apb(1'b1, wg_pkg::IDX_CLKDIV, {d2[3:0], 4'h0});
    apb(1'b1, wg_pkg::IDX_DIVSEL, 8'h40);
    apb(1'b1, wg_pkg::IDX_N6, 8'h03);
    apb(1'b1, wg_pkg::IDX_N7, 8'h04);
    apb(1'b1, wg_pkg::IDX_CFG, 8'h08);
    idle(4);
    chk("8-bit drive", 32'h3, {30'h0, drive[7:6]});
    wait_cnt(6, 16'h0003);
    idle(400);
    chk("pad6 pulses", 32'h3, {16'h0, cnt[6]});
    chk("pad7 pulses", 32'h4, {16'h0, cnt[7]});
    chk("pad6 period", {16'h0, exp_per({8'h00, t46}, d2)}, {16'h0, per[6]});
    chk("pad7 period", {16'h0, exp_per(16'h0000, 8'h00)}, {16'h0, per[7]});
    apb(1'b0, wg_pkg::IDX_N6, 8'h00);
    chk("count left", 32'h0, {24'h0, rd});
    apb(1'b0, wg_pkg::IDX_N7, 8'h00);
    chk("pad7 count left", 32'h0, {24'h0, rd});
    // 16-bit pair 3: subperiod {1,0} = 256, count {0,3}
    restart();
    apb(1'b1, wg_pkg::IDX_DIVSEL, 8'h00);
    apb(1'b1, wg_pkg::IDX_CLKDIV, 8'h00);
    apb(1'b1, wg_pkg::IDX_T47, 8'h01);
    apb(1'b1, wg_pkg::IDX_T46, 8'h00);
    apb(1'b1, wg_pkg::IDX_N7, 8'h00);
    apb(1'b1, wg_pkg::IDX_N6, 8'h03);
    apb(1'b1, wg_pkg::IDX_CFG, 8'h88);
    idle(1500);
    chk("16-bit drive", 32'h1, {30'h0, drive[7:6]});
    apb(1'b0, wg_pkg::IDX_N7, 8'h00);
    chk("count high byte", 32'h0, {24'h0, rd});
    apb(1'b0, wg_pkg::IDX_N6, 8'h00);
    chk("count low byte", 32'h2, {24'h0, rd});
    wait_cnt(6, 16'h0003);
    idle(1200);
    chk("16-bit pulses", 32'h3, {16'h0, cnt[6]});
    chk("16-bit period", {16'h0, exp_per(16'h0100, 8'h00)}, {16'h0, per[6]});
    // zero count runs forever; suspend and per-pad reset stop it
    restart();
    apb(1'b1, wg_pkg::IDX_T46, 8'h00);
    apb(1'b1, wg_pkg::IDX_N6, 8'h00);
    apb(1'b1, wg_pkg::IDX_CFG, 8'h08);
    idle(400);
    chk("endless run", 32'h1, {31'h0, cnt[6] > 16'd90});
    apb(1'b1, wg_pkg::IDX_SUSP, 8'h40);
    idle(20);
    c = cnt[6];
    idle(100);
    chk("suspended", {16'h0, c}, {16'h0, cnt[6]});
    apb(1'b1, wg_pkg::IDX_SUSP, 8'h00);
    idle(100);
    chk("resumed", 32'h1, {31'h0, cnt[6] > c});
    apb(1'b1, wg_pkg::IDX_WRESET, 8'h40);
    idle(3);
    c = cnt[6];
    idle(100);
    chk("reset halt", {16'h0, c}, {16'h0, cnt[6]});
    chk("reset level", 32'h0, {31'h0, wave[6]});
    // chain bit 6: pad 6 waits for pad 7 to finish
    restart();
    apb(1'b1, wg_pkg::IDX_CHAIN, 8'h40);
    apb(1'b1, wg_pkg::IDX_N6, 8'h01);
    apb(1'b1, wg_pkg::IDX_N7, 8'h02);
    apb(1'b1, wg_pkg::IDX_CFG, 8'h08);
    wait_cnt(7, 16'h0001);
    chk("chain waiting", 32'h0, {16'h0, cnt[6]});
    idle(300);
    chk("chain started", 32'h1, {16'h0, cnt[6]});
    apb(1'b1, wg_pkg::IDX_CFG, 8'h00);
    idle(4);
    chk("disabled drive", 32'h0, {24'h0, drive});
    complete_run();
  end
endmodule
